// File: hw/wff_match.v
// Wake-up frame pattern filters: configuration store, APB slave, per-filter
// masked CRC-16 over received bytes, pattern compare and wake interrupt.
// Assumes frame bytes from the MAC receive datapath on pclk, one per valid.
//
// Our own choices: the APB slave port and the register offsets.
`include "wff_regs.vh"
`default_nettype none

module wff_match
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // Receive byte stream from the MAC
   input wire rx_valid,
   input wire rx_first,
   input wire rx_last,
   input wire [7:0] rx_data,
   // Power management outputs
   output reg rx_normal_enable,
   output reg wake_frame_received_flag,
   output reg [3:0] wake_filter_hit,
   output reg wake_irq
);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire setup_ph = psel & ~penable;
   wire access_done = psel & penable;
   wire wr_done = access_done & pwrite;
   wire rd_done = access_done & ~pwrite;
   wire sel_filter = (paddr == `WFF_OFS_FILTER);
   wire sel_ctrl = (paddr == `WFF_OFS_CTRL);
   wire sel_stat = (paddr == `WFF_OFS_IRQ_STAT);
   wire sel_mask = (paddr == `WFF_OFS_IRQ_MASK);
   wire sel_any = sel_filter | sel_ctrl | sel_stat | sel_mask;

   // Zero wait states: read data is fetched in the setup cycle
   assign pready = 1'b1;

   // ----------------------------------------------------------------------
   // Configuration store
   // ----------------------------------------------------------------------
   reg [31:0] cfg_mem [0:7];
   reg [2:0] cfg_ptr;
   reg wake_frame_detect_enable;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   wire [3:0] filt_match;
   integer n;

   // Sequential port: every access moves the word pointer, wrapping after
   // eight, so an interrupted load is finished by completing the eight.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (n = 0; n < `WFF_NWORDS; n = n + 1)
            cfg_mem[n] <= `WFF_CFG_RESET;
         cfg_ptr <= 3'h0;
      end
      else if (access_done & sel_filter)
      begin
         if (pwrite)
            cfg_mem[cfg_ptr] <= pwdata;
         cfg_ptr <= (cfg_ptr == `WFF_PTR_LAST) ? 3'h0 : cfg_ptr + 3'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Control, status and interrupt registers
   // ----------------------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_frame_detect_enable <= 1'b0;
         wake_frame_received_flag <= 1'b0;
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
         wake_filter_hit <= 4'h0;
      end
      else
      begin
         if (wr_done & sel_ctrl)
            wake_frame_detect_enable <= pwdata[`WFF_CTRL_EN];
         if (wr_done & sel_mask)
            irq_mask <= pwdata[3:0];
         // A match in the clearing cycle survives
         if (|filt_match)
            wake_frame_received_flag <= 1'b1;
         else if (wr_done & sel_ctrl & pwdata[`WFF_CTRL_RCVD])
            wake_frame_received_flag <= 1'b0;
         if (rd_done & sel_stat)
            irq_stat <= filt_match;
         else
            irq_stat <= irq_stat | filt_match;
         if (|filt_match)
            wake_filter_hit <= filt_match;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_irq <= 1'b0;
         rx_normal_enable <= 1'b1;
      end
      else
      begin
         wake_irq <= |(irq_stat & irq_mask);
         rx_normal_enable <= ~wake_frame_detect_enable;
      end
   end

   // ----------------------------------------------------------------------
   // Read data and error answer
   // ----------------------------------------------------------------------
   reg [31:0] next_prdata;

   always @*
   begin
      next_prdata = 32'h0000_0000;
      if (sel_filter)
         next_prdata = cfg_mem[cfg_ptr];
      else if (sel_ctrl)
      begin
         next_prdata[`WFF_CTRL_EN] = wake_frame_detect_enable;
         next_prdata[`WFF_CTRL_RCVD] = wake_frame_received_flag;
         next_prdata[`WFF_CTRL_PTR_LO +: `WFF_PTR_W] = cfg_ptr;
      end
      else if (sel_stat)
         next_prdata[`WFF_STAT_W-1:0] = irq_stat;
      else if (sel_mask)
         next_prdata[`WFF_STAT_W-1:0] = irq_mask;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= ~sel_any;
      end
   end

   // ----------------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------------
   reg [8:0] byte_cnt;
   reg frame_mcast;
   wire [8:0] cur_pos = rx_first ? 9'h000 : byte_cnt;
   wire cur_mcast = rx_first ? rx_data[`WFF_DA_MCAST_BIT] : frame_mcast;
   // Only frames whose last byte arrives while detection is on are checked
   wire check_on = wake_frame_detect_enable;

   // Counter saturates; no mask window reaches that far
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         byte_cnt <= 9'h000;
         frame_mcast <= 1'b0;
      end
      else if (rx_valid)
      begin
         if (cur_pos != `WFF_CNT_MAX)
            byte_cnt <= cur_pos + 9'h001;
         if (rx_first)
            frame_mcast <= rx_data[`WFF_DA_MCAST_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Per-filter masked CRC and compare
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `WFF_NFILT; i = i + 1)
      begin : g_filt
         // Field extraction from the shared words
         wire [31:0] mask = cfg_mem[i];
         wire [7:0] cmd = cfg_mem[`WFF_WORD_CMD][i*`WFF_CMD_STRIDE +: 8];
         wire [7:0] ofs = cfg_mem[`WFF_WORD_OFFSET][i*`WFF_OFFSET_W +: 8];
         wire [15:0] pat = cfg_mem[`WFF_WORD_CRC_LO + i/2][(i%2)*`WFF_CRC_W +: 16];
         // Reserved command bits are simply not looked at
         wire en = cmd[`WFF_CMD_EN];
         wire want_mcast = cmd[`WFF_CMD_MCAST];
         wire [8:0] rel = cur_pos - {1'b0, ofs};
         wire in_win = (cur_pos >= {1'b0, ofs}) && (rel < `WFF_MASK_BITS);
         // Bit 31 never selects a byte even if written
         wire take = in_win & mask[rel[4:0]];
         reg [15:0] crc;
         wire [15:0] crc_base = rx_first ? `WFF_CRC_INIT : crc;
         wire [15:0] crc_step;
         wire [15:0] crc_now = (rx_valid & take) ? crc_step : crc_base;

         wff_crc16 u_crc
         (
            .crc_in(crc_base),
            .data(rx_data),
            .crc_out(crc_step)
         );

         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               crc <= `WFF_CRC_INIT;
            else if (rx_valid)
               crc <= crc_now;
         end

         // Decision on the last byte, which itself may be masked in
         assign filt_match[i] = rx_valid & rx_last & check_on & en
                                & (cur_mcast == want_mcast)
                                & (crc_now == pat);
      end
   endgenerate

endmodule

`default_nettype wire

// File: hw/wff_regs.vh
// Constants for the wake-up frame pattern filter block: register offsets,
// field positions, reset values and CRC-16 parameters.
// Assumes inclusion by bare name from the design files.
`ifndef WFF_REGS_VH
`define WFF_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the APB)
// ----------------------------------------------------------------------
`define WFF_ADDR_W 12
`define WFF_OFS_FILTER 12'h000
`define WFF_OFS_CTRL 12'h004
`define WFF_OFS_IRQ_STAT 12'h008
`define WFF_OFS_IRQ_MASK 12'h00c

// ----------------------------------------------------------------------
// Filter configuration layout
// ----------------------------------------------------------------------
`define WFF_NFILT 4
`define WFF_NWORDS 8
`define WFF_PTR_W 3
`define WFF_PTR_LAST 3'h7
`define WFF_WORD_CMD 3'h4
`define WFF_WORD_OFFSET 3'h5
`define WFF_WORD_CRC_LO 6
`define WFF_CMD_STRIDE 8
`define WFF_CMD_EN 0
`define WFF_CMD_MCAST 3
`define WFF_OFFSET_W 8
`define WFF_CRC_W 16
`define WFF_MASK_BITS 31
`define WFF_CFG_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Control / status fields
// ----------------------------------------------------------------------
`define WFF_CTRL_EN 0
`define WFF_CTRL_RCVD 1
`define WFF_CTRL_PTR_LO 8
`define WFF_STAT_W 4

// ----------------------------------------------------------------------
// Frame byte counter and CRC engine
// ----------------------------------------------------------------------
`define WFF_CNT_W 9
`define WFF_CNT_MAX 9'h1ff
`define WFF_MASK_SPAN 9'h01f
`define WFF_DA_MCAST_BIT 0
`define WFF_CRC_INIT 16'hffff
`define WFF_CRC_POLY 16'ha001

`endif

// File: hw/wff_crc16.v
// One byte step of the reflected CRC-16 used by the wake-up filters.
// Assumes a purely combinational use; the caller holds the running value.
`include "wff_regs.vh"
`default_nettype none

module wff_crc16
(
   // Running value in
   input wire [15:0] crc_in,
   // Byte to fold in, bit 0 first
   input wire [7:0] data,
   // Updated value
   output reg [15:0] crc_out
);

   reg [15:0] c;
   integer k;

   // ----------------------------------------------------------------------
   // Bit-serial fold, unrolled by the tool
   // ----------------------------------------------------------------------
   always @*
   begin
      c = crc_in ^ {8'h00, data};
      for (k = 0; k < 8; k = k + 1)
      begin
         if (c[0])
            c = (c >> 1) ^ `WFF_CRC_POLY;
         else
            c = c >> 1;
      end
      crc_out = c;
   end

endmodule

`default_nettype wire

// File: test/wff_rx_model.sv
// Receive byte source standing in for the MAC datapath.
// Assumes the caller enters send just after a rising pclk edge.
`default_nettype none
module wff_rx_model
(
   // Clock
   input wire logic pclk,
   // Byte stream
   output logic rx_valid,
   output logic rx_first,
   output logic rx_last,
   output logic [7:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LEN = 20;
   initial {rx_valid, rx_first, rx_last, rx_data} = '0;
   // ----
   // Frame content
   // ----
   function automatic logic [7:0] fb(input int p, input logic mc);
      return (p == 0) ? {7'h00, mc} : 8'(p * 37);
   endfunction
   // Slow mode leaves a gap after each byte; idle data is inverted
   task automatic send(input logic mc, input logic slow);
      for (int p = 0; p < LEN; p++)
      begin
         rx_valid <= 1;
         rx_first <= (p == 0);
         rx_last <= (p == LEN - 1);
         rx_data <= fb(p, mc);
         @(posedge pclk);
         if (slow)
         begin
            {rx_valid, rx_first, rx_last} <= 3'h0;
            rx_data <= ~fb(p, mc);
            @(posedge pclk);
         end
      end
      {rx_valid, rx_first, rx_last} <= 3'h0;
      rx_data <= ~fb(LEN - 1, mc);
   endtask
endmodule
`default_nettype wire

// File: test/wff_match_asserts.sv
// Port checks for wff_match.
// Assumes a bind onto wff_match; sees its ports only.
`default_nettype none
module wff_match_asserts
(
   // Watched ports
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic rx_last,
   input wire logic rx_normal_enable,
   input wire logic wake_frame_received_flag,
   input wire logic [3:0] wake_filter_hit,
   input wire logic wake_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire lst = rx_valid & rx_last;
   wire flg = wake_frame_received_flag;
   wire acc = psel & penable;
   wire set = psel & ~penable;
   // ----
   // Checks
   // ----
   a_flag_cause: assert property ($rose(flg) |-> $past(lst) && !rx_normal_enable)
      else $error("flag rose without a frame end");
   a_hit_cause: assert property ($changed(wake_filter_hit) |-> $past(lst))
      else $error("hit changed off a frame end");
   a_hit_flag: assert property ($changed(wake_filter_hit) |-> flg)
      else $error("hit without flag");
   // A mask write may also raise or drop the interrupt with status pending
   wire mwr = acc & pwrite & (paddr == 12'h00c);
   a_irq_rise: assert property ($rose(wake_irq) |-> $past(lst, 2) || $past(mwr, 2))
      else $error("irq rose late or early");
   a_irq_drop: assert property ($fell(wake_irq) |->
      $past(acc && !pwrite && paddr == 12'h008, 2) || $past(mwr, 2))
      else $error("irq fell without status read");
   a_normal_lag: assert property ($changed(rx_normal_enable) |-> $past(acc && pwrite && paddr == 12'h004, 2))
      else $error("normal reception moved by itself");
   a_err_unmapped: assert property (set && paddr > 12'h00c |=> pslverr)
      else $error("unmapped access not refused");
   a_map_ok: assert property (set && paddr <= 12'h00c && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   a_err_zero: assert property (acc && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   c_match: cover property ($rose(flg));
   c_irq_clr: cover property ($fell(wake_irq));
   c_err: cover property (acc && pslverr);
endmodule
bind wff_match wff_match_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .rx_valid(rx_valid), .rx_last(rx_last), .rx_normal_enable(rx_normal_enable),
   .wake_frame_received_flag(wake_frame_received_flag),
   .wake_filter_hit(wake_filter_hit), .wake_irq(wake_irq));
`default_nettype wire

// File: test/wff_match_tb.sv
// Bench for wff_match: APB tasks plus a receive byte model.
// Assumes wff_regs.vh on the include path.
`include "wff_regs.vh"
`default_nettype none
module wff_match_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q, w[8];
   logic pready, pslverr, rx_valid, rx_first, rx_last, rx_normal_enable, flg, irq, e;
   logic [7:0] rx_data;
   logic [3:0] hit;
   int fail_count = 0, num_checks = 0;
   initial forever #5 pclk = ~pclk;
   wff_rx_model rx_u (.pclk(pclk), .rx_valid(rx_valid), .rx_first(rx_first),
      .rx_last(rx_last), .rx_data(rx_data));
   wff_match dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_first(rx_first), .rx_last(rx_last),
      .rx_data(rx_data), .rx_normal_enable(rx_normal_enable),
      .wake_frame_received_flag(flg), .wake_filter_hit(hit), .wake_irq(irq));
   // ----
   // Tasks
   // ----
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   // Bounded wait: a stuck pready ends the run
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         chk(0, 1);
         give_verdict;
      end
      else
      begin
         q = prdata;
         e = pslverr;
         psel <= 0;
         penable <= 0;
         @(posedge pclk);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      bus(0, a, 0);
      chk(q, x);
   endtask
   function automatic logic [15:0] crc(input logic [30:0] m, input int o, input logic mc);
      logic [15:0] c;
      logic [7:0] b;
      c = `WFF_CRC_INIT;
      for (int j = 0; j < 31; j++)
         if (m[j])
         begin
            b = rx_u.fb(o + j, mc);
            for (int k = 0; k < 8; k++)
               c = (c[0] ^ b[k]) ? (c >> 1) ^ `WFF_CRC_POLY : c >> 1;
         end
      return c;
   endfunction
   // Frame then two edges so flag, hit and irq have landed
   task automatic frame(input logic mc, input logic slow);
      rx_u.send(mc, slow);
      repeat (2) @(posedge pclk);
   endtask
   // ----
   // Sequence
   // ----
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk(rx_normal_enable, 1);
      rd(`WFF_OFS_CTRL, 0);
      rd(`WFF_OFS_IRQ_MASK, 0);
      rd(12'h010, 0);
      chk(e, 1);
      $display("test reset done");
      // Filter 2 disabled, filter 3 wrong pattern, 1 multicast only
      w = '{32'h5, 32'h3, 32'h5, 32'h5, 32'h01000901, 32'h0c0c0d0c, 0, 0};
      w[6] = {crc(3, 13, 1), crc(5, 12, 0)};
      w[7] = {~w[6][15:0], w[6][15:0]};
      for (int i = 0; i < 8; i++) bus(1, `WFF_OFS_FILTER, w[i]);
      for (int i = 0; i < 8; i++) rd(`WFF_OFS_FILTER, w[i]);
      bus(1, `WFF_OFS_IRQ_MASK, 32'hf);
      bus(1, `WFF_OFS_CTRL, 1);
      $display("test load done");
      frame(0, 0);
      chk(hit, 1);
      chk(irq, 1);
      chk(rx_normal_enable, 0);
      rd(`WFF_OFS_CTRL, 3);
      rd(`WFF_OFS_IRQ_STAT, 1);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      rd(`WFF_OFS_IRQ_STAT, 0);
      bus(1, `WFF_OFS_CTRL, 3);
      rd(`WFF_OFS_CTRL, 1);
      $display("test unicast done");
      bus(1, `WFF_OFS_IRQ_MASK, 1);
      frame(1, 1);
      chk(hit, 2);
      chk(irq, 0);
      rd(`WFF_OFS_IRQ_STAT, 2);
      $display("test multicast done");
      bus(1, `WFF_OFS_CTRL, 0);
      frame(0, 0);
      chk(hit, 2);
      chk(rx_normal_enable, 1);
      rd(`WFF_OFS_IRQ_STAT, 0);
      rd(`WFF_OFS_CTRL, 2);
      $display("test disabled done");
      give_verdict;
   end
endmodule
`default_nettype wire
